/* File: rtl/scpa_top.sv */
// strap capture at reset release and output phase adjust controller
//
// Summary of operation
// [RQ1] sample five straps at reset release
// [RQ2] keep sampled straps readable as status
// [RQ3] shared pins become serial port after reset
// [RQ4] board holds test strap low
// [RQ5] interface straps pick I2C address or SPI
// [RQ6] auto-config straps pick output setup
// [RQ7] every config expects 25MHz crystal
// [RQ8] ref select 10 oscillator, 01 crystal
// [RQ9] polarity bit inverts output clock
// [RQ10] drive field picks one of four
// [RQ11] phase step is half a synthesis period
// [RQ12] adjust relative to latest own phase
// [RQ13] software sets mode, enable, amount first
// [RQ14] arm on rising arm bit
// [RQ15] armed controller fires on rising trigger
// [RQ16] one trigger moves many outputs independently
// [RQ17] only enabled nonzero outputs move
// [RQ18] negative limit two periods, positive limited
// [RQ19] clear bit cancels arm, returns idle
// [RQ20] status shows armed and busy live
// [RQ21] sticky done flag on completion
// [RQ22] amount counts half periods
// [RQ23] software clears, arms, then triggers
// [RQ24] rearm and retrigger repeats the amount
// [RQ25] ready output low until ready
// [RQ26] unarmed trigger is ignored
// [RQ27] straps latch once per reset
`timescale 1ns/1ps
module scpa_top (
  // clock and reset
  input  wire logic                                   REF_CLK,
  input  wire logic                                   SYS_RST,
  // shared strap pins, read at reset release
  input  wire logic                                   TEST_PIN,
  input  wire logic [1:0]                             AUTO_CONFIG_STRAPS,
  input  wire logic                                   IF0_CS_N_PIN,
  input  wire logic                                   IF1_MISO_PIN,
  // serial port data to drive on the shared data pin
  input  wire logic                                   SPI_MISO_DATA,
  input  wire logic                                   SPI_MISO_EN,
  // per-output controls and reference input select
  input  wire logic [scpa_pkg::NUM_OUT-1:0]           OUT_INVERT,
  input  wire logic [scpa_pkg::NUM_OUT*2-1:0]         OUT_DRIVE_LEVEL,
  input  wire logic [scpa_pkg::NUM_OUT-1:0]           OUT_PHASE_ENABLE,
  input  wire logic [scpa_pkg::NUM_OUT*scpa_pkg::AMT_W-1:0] OUT_PHASE_AMOUNT,
  input  wire logic [1:0]                             REF_INPUT_SELECT,
  // phase control bits
  input  wire logic                                   PHASE_OP_SELECT,
  input  wire logic                                   PHASE_ARM_BIT,
  input  wire logic                                   PHASE_FIRE_BIT,
  input  wire logic                                   PHASE_SM_CLEAR,
  input  wire logic                                   ADJUST_DONE_CLEAR,
  // strap results
  output logic [4:0]                                  STRAP_CAPTURE_STATUS,
  output logic                                        TEST_MODE,
  output logic                                        SPI_MODE,
  output logic [6:0]                                  I2C_SLAVE_ADDR,
  output scpa_pkg::scpa_outcfg_type [scpa_pkg::NUM_OUT-1:0] OUT_CONFIG,
  // reference input control
  output logic                                        XTAL_DRIVER_EN,
  output logic                                        XTAL_IN_SE_EN,
  // shared pin second role
  output logic                                        CS_N_TO_PORT,
  output logic                                        MISO_OUT,
  output logic                                        MISO_OE,
  // per-output driver controls
  output logic [scpa_pkg::NUM_OUT-1:0]                OUT_INVERT_Q,
  output logic [scpa_pkg::NUM_OUT*2-1:0]              OUT_DRIVE_Q,
  // phase state, in half synthesis periods
  output logic [scpa_pkg::NUM_OUT*scpa_pkg::PHASE_W-1:0] OUT_PHASE,
  output scpa_pkg::scpa_status_type                   PHASE_STATUS,
  output logic                                        READY
);

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} scpa_state_type;

  // synchronisers for the strap and serial pins
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [4:0] pin_now;
  logic [4:0] strap_r;
  logic       captured_r;
  // synchroniser for reset release so the strap catch follows the edge
  logic       rel_s1_r;
  logic       rel_s2_r;

  scpa_state_type state_r;
  scpa_state_type state_nxt;
  logic           arm_d_r;
  logic           fire_d_r;
  logic [3:0]     busy_cnt_r;
  logic           done_r;
  logic           ready_r;
  logic [scpa_pkg::NUM_OUT*scpa_pkg::PHASE_W-1:0] phase_r;
  logic [scpa_pkg::NUM_OUT*scpa_pkg::PHASE_W-1:0] phase_nxt;
  logic [scpa_pkg::NUM_OUT-1:0] part_r;

  // sign-extend and clamp a half-period amount to the allowed range
  function automatic logic [scpa_pkg::PHASE_W-1:0] clamp_amt(
    input logic [scpa_pkg::AMT_W-1:0] a
  );
    logic signed [scpa_pkg::AMT_W-1:0] s;
    s = $signed(a);
    if (s < scpa_pkg::AMT_NEG_MAX)
      s = scpa_pkg::AMT_NEG_MAX;
    else if (s > scpa_pkg::AMT_POS_MAX)
      s = scpa_pkg::AMT_POS_MAX;
    return {{(scpa_pkg::PHASE_W-scpa_pkg::AMT_W){s[scpa_pkg::AMT_W-1]}}, s};
  endfunction

  // decode setup for one output from the auto-config code
  function automatic scpa_pkg::scpa_outcfg_type cfg_of(
    input logic [1:0] ac,
    input int         idx
  );
    scpa_pkg::scpa_outcfg_type c;
    c = '{fmt: scpa_pkg::FMT_OFF, freq_mhz: 8'h00};
    if (idx == 0)
      c = '{fmt: scpa_pkg::FMT_CML, freq_mhz: scpa_pkg::FREQ_100};
    else if (idx == 1 && ac != 2'h0)
      c = '{fmt: (ac == 2'h2) ? scpa_pkg::FMT_HSTL : scpa_pkg::FMT_CML,
            freq_mhz: scpa_pkg::FREQ_100};
    else if (idx == 2 && ac == 2'h3)
      c = '{fmt: scpa_pkg::FMT_CMOS, freq_mhz: scpa_pkg::FREQ_25};
    return c;
  endfunction

  // pin vector: test, ac1, ac0, if1, if0
  assign pin_now = {TEST_PIN, AUTO_CONFIG_STRAPS, IF1_MISO_PIN, IF0_CS_N_PIN};

  // two-flop synchronisers for pins and reset release
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      rel_s1_r <= 1'b0;
      rel_s2_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= pin_now;
      pin_s2_r <= pin_s1_r;
      rel_s1_r <= 1'b1;
      rel_s2_r <= rel_s1_r;
    end
  end

  // [RQ1] [RQ27] one catch after release
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      strap_r    <= scpa_pkg::STRAP_RST;
      captured_r <= 1'b0;
    end
    else if (rel_s2_r && !captured_r)
    begin
      strap_r    <= pin_s2_r;
      captured_r <= 1'b1;
    end
  end

  // [RQ2] [RQ5] [RQ6] latched configuration outputs
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      STRAP_CAPTURE_STATUS <= scpa_pkg::STRAP_RST;
      TEST_MODE            <= 1'b0;
      SPI_MODE             <= 1'b0;
      I2C_SLAVE_ADDR       <= 7'h00;
      OUT_CONFIG           <= '0;
      ready_r              <= 1'b0;
    end
    else
    begin
      STRAP_CAPTURE_STATUS <= strap_r;
      TEST_MODE            <= strap_r[scpa_pkg::STRAP_TEST_POS];
      SPI_MODE             <= (strap_r[1:0] == scpa_pkg::IF_CODE_SPI);
      I2C_SLAVE_ADDR       <= {scpa_pkg::I2C_ADDR_HI, strap_r[1:0]};
      for (int i = 0; i < scpa_pkg::NUM_OUT; i++)
        OUT_CONFIG[i] <= cfg_of(strap_r[scpa_pkg::STRAP_AC1_POS:scpa_pkg::STRAP_AC0_POS], i);
      // [RQ25] ready once straps are in
      ready_r <= captured_r;
    end
  end

  // [RQ3] [RQ7] [RQ8] [RQ9] [RQ10] pin roles and driver controls
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      CS_N_TO_PORT   <= 1'b1;
      MISO_OUT       <= 1'b0;
      MISO_OE        <= 1'b0;
      XTAL_DRIVER_EN <= 1'b0;
      XTAL_IN_SE_EN  <= 1'b0;
      OUT_INVERT_Q   <= '0;
      OUT_DRIVE_Q    <= '0;
    end
    else
    begin
      CS_N_TO_PORT   <= captured_r ? pin_s2_r[scpa_pkg::STRAP_IF0_POS] : 1'b1;
      MISO_OUT       <= SPI_MISO_DATA;
      MISO_OE        <= captured_r && SPI_MISO_EN;
      // crystal is the auto-config default, only the oscillator code turns it off
      XTAL_DRIVER_EN <= (REF_INPUT_SELECT != scpa_pkg::REF_SEL_OSC);
      XTAL_IN_SE_EN  <= (REF_INPUT_SELECT == scpa_pkg::REF_SEL_OSC);
      OUT_INVERT_Q   <= OUT_INVERT;
      OUT_DRIVE_Q    <= OUT_DRIVE_LEVEL;
    end
  end

  // rising edges of arm and trigger bits, and the last busy cycle
  logic arm_rise;
  logic fire_rise;
  logic busy_end;
  assign arm_rise  = PHASE_ARM_BIT && !arm_d_r;
  assign fire_rise = PHASE_FIRE_BIT && !fire_d_r;
  assign busy_end  = (state_r == ST_BUSY) && (busy_cnt_r == 4'h1);

  // [RQ14] [RQ15] [RQ19] [RQ26] controller next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (arm_rise && PHASE_OP_SELECT)
          state_nxt = ST_ARMED;
      ST_ARMED:
        if (fire_rise)
          state_nxt = ST_BUSY;
      ST_BUSY:
        if (busy_end)
          state_nxt = ST_IDLE;
    endcase
    if (PHASE_SM_CLEAR)
      state_nxt = ST_IDLE;
  end

  // [RQ12] [RQ16] [RQ17] [RQ22] relative per-output step
  always_comb
  begin
    phase_nxt = phase_r;
    for (int i = 0; i < scpa_pkg::NUM_OUT; i++)
      if (part_r[i] && busy_end)
        phase_nxt[i*scpa_pkg::PHASE_W +: scpa_pkg::PHASE_W] =
          phase_r[i*scpa_pkg::PHASE_W +: scpa_pkg::PHASE_W] +
          clamp_amt(OUT_PHASE_AMOUNT[i*scpa_pkg::AMT_W +: scpa_pkg::AMT_W]);
  end

  // [RQ11] [RQ18] [RQ24] controller registers
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_r    <= ST_IDLE;
      arm_d_r    <= 1'b0;
      fire_d_r   <= 1'b0;
      busy_cnt_r <= 4'h0;
      part_r     <= '0;
      phase_r    <= {scpa_pkg::NUM_OUT{scpa_pkg::PHASE_RST}};
    end
    else
    begin
      state_r  <= state_nxt;
      arm_d_r  <= PHASE_ARM_BIT;
      fire_d_r <= PHASE_FIRE_BIT;
      phase_r  <= phase_nxt;
      if (state_r == ST_ARMED && fire_rise)
      begin
        busy_cnt_r <= scpa_pkg::BUSY_CYC_W;
        for (int i = 0; i < scpa_pkg::NUM_OUT; i++)
          part_r[i] <= OUT_PHASE_ENABLE[i] &&
            (OUT_PHASE_AMOUNT[i*scpa_pkg::AMT_W +: scpa_pkg::AMT_W] != 8'h00);
      end
      else if (busy_cnt_r != 4'h0)
        busy_cnt_r <= busy_cnt_r - 4'h1;
    end
  end

  // [RQ20] [RQ21] live and sticky status, set wins
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      done_r <= 1'b0;
    else if (busy_end && !PHASE_SM_CLEAR)
      done_r <= 1'b1;
    else if (ADJUST_DONE_CLEAR)
      done_r <= 1'b0;
  end

  // registered status and phase view
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PHASE_STATUS <= '0;
      OUT_PHASE    <= '0;
      READY        <= 1'b0;
    end
    else
    begin
      PHASE_STATUS.armed       <= (state_nxt == ST_ARMED);
      PHASE_STATUS.busy        <= (state_nxt == ST_BUSY);
      PHASE_STATUS.done_sticky <= done_r;
      OUT_PHASE                <= phase_r;
      READY                    <= ready_r;
    end
  end

endmodule // scpa_top

/* File: rtl/scpa_pkg.sv */
// shared constants and types for strap capture and phase adjust
package scpa_pkg;
  localparam int NUM_OUT = 3;
  localparam int AMT_W = 8;
  localparam int PHASE_W = 16;
  // strap capture field positions
  localparam int STRAP_IF0_POS  = 0;
  localparam int STRAP_IF1_POS  = 1;
  localparam int STRAP_AC0_POS  = 2;
  localparam int STRAP_AC1_POS  = 3;
  localparam int STRAP_TEST_POS = 4;
  localparam logic [4:0] STRAP_RST = 5'h00;
  // host interface decode
  localparam logic [4:0] I2C_ADDR_HI = 5'h1B;
  localparam logic [1:0] IF_CODE_SPI = 2'h3;
  // reference input select codes
  localparam logic [1:0] REF_SEL_XTAL = 2'h1;
  localparam logic [1:0] REF_SEL_OSC  = 2'h2;
  // output format codes
  localparam logic [1:0] FMT_OFF  = 2'h0;
  localparam logic [1:0] FMT_CML  = 2'h1;
  localparam logic [1:0] FMT_HSTL = 2'h2;
  localparam logic [1:0] FMT_CMOS = 2'h3;
  // nominal frequencies in MHz
  localparam logic [7:0] FREQ_100 = 8'h64;
  localparam logic [7:0] FREQ_25  = 8'h19;
  // synthesis clock step in ps (600 MHz)
  localparam int STEP_PS = 1667;
  // limits in half-period units
  localparam logic signed [AMT_W-1:0] AMT_NEG_MAX = 8'shFC;
  localparam logic signed [AMT_W-1:0] AMT_POS_MAX = 8'sh30;
  // busy time of one adjustment in REF_CLK cycles
  localparam int BUSY_NS = 100;
  localparam int CLK_NS = 50;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] BUSY_CYC_W = 4'(BUSY_CYC);
  localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;

  typedef struct packed {
    logic [1:0] fmt;
    logic [7:0] freq_mhz;
  } scpa_outcfg_type;

  typedef struct packed {
    logic armed;
    logic busy;
    logic done_sticky;
  } scpa_status_type;
endpackage

/* File: verif/scpa_strap_model.sv */
// board strap resistors, replaced by serial port traffic after reset
`timescale 1ns/1ps
module scpa_strap_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // strap code {ac1,ac0,if1,if0}
  input  wire logic [3:0] code,
  // strap pins
  output logic            test_pin,
  output logic [3:0]      pins
);
  logic [3:0] hold_r;

  // count the strap hold window after release
  always_ff @(posedge clk or posedge rst)
    if (rst)
      hold_r <= 4'h0;
    else if (hold_r != 4'hF)
      hold_r <= hold_r + 4'h1;

  assign test_pin = 1'b0;
  // pins leave strap level after hold
  assign pins = (hold_r < 4'h8) ? code : ~code;
endmodule // scpa_strap_model

/* File: verif/scpa_top_sva.sv */
// phase controller and strap checks at the top ports
`timescale 1ns/1ps
module scpa_top_sva (
  // clock and reset
  input wire logic                      REF_CLK,
  input wire logic                      SYS_RST,
  // watched ports
  input wire logic                      PHASE_OP_SELECT,
  input wire logic                      PHASE_ARM_BIT,
  input wire logic                      PHASE_FIRE_BIT,
  input wire logic                      PHASE_SM_CLEAR,
  input wire logic [1:0]                REF_INPUT_SELECT,
  input wire logic [4:0]                STRAP_CAPTURE_STATUS,
  input wire logic                      SPI_MODE,
  input wire logic [6:0]                I2C_SLAVE_ADDR,
  input wire logic                      XTAL_DRIVER_EN,
  input wire logic                      XTAL_IN_SE_EN,
  input wire scpa_pkg::scpa_status_type PHASE_STATUS,
  input wire logic                      READY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  AST_ARM: assert property ($rose(PHASE_ARM_BIT) && PHASE_OP_SELECT && !PHASE_SM_CLEAR
    && PHASE_STATUS[2:1] == 2'h0 |=> PHASE_STATUS.armed) else $error("arm not taken");
  AST_FIRE: assert property (PHASE_STATUS.armed && $rose(PHASE_FIRE_BIT) && !PHASE_SM_CLEAR
    |=> PHASE_STATUS.busy && !PHASE_STATUS.armed) else $error("fire not taken");
  AST_NOFIRE: assert property ($rose(PHASE_FIRE_BIT) && PHASE_STATUS[2:1] == 2'h0
    |=> !PHASE_STATUS.busy) else $error("unarmed fire acted");
  AST_BUSY: assert property ($rose(PHASE_STATUS.busy)
    |-> PHASE_STATUS.busy[*2] ##1 !PHASE_STATUS.busy) else $error("busy length wrong");
  AST_DONE: assert property ($fell(PHASE_STATUS.busy) && !$past(PHASE_SM_CLEAR)
    |=> PHASE_STATUS.done_sticky) else $error("done flag missing");
  AST_CLR: assert property (PHASE_SM_CLEAR
    |=> !PHASE_STATUS.armed && !PHASE_STATUS.busy) else $error("clear did not idle");
  AST_REF: assert property ($stable(REF_INPUT_SELECT) && !$past(SYS_RST)
    |-> XTAL_DRIVER_EN == (REF_INPUT_SELECT != 2'h2)
    && XTAL_IN_SE_EN == (REF_INPUT_SELECT == 2'h2)) else $error("ref select decode wrong");
  AST_HOLD: assert property (READY && $past(READY)
    |-> $stable(STRAP_CAPTURE_STATUS)) else $error("strap status moved");
  AST_IF: assert property (READY |-> SPI_MODE == (STRAP_CAPTURE_STATUS[1:0] == 2'h3)
    && I2C_SLAVE_ADDR == {5'h1B, STRAP_CAPTURE_STATUS[1:0]}) else $error("host port decode");

  // main scenarios reached
  COV_ARM: cover property (PHASE_STATUS.armed);
  COV_DONE: cover property (PHASE_STATUS.done_sticky);
  COV_SPI: cover property (READY && SPI_MODE);
endmodule // scpa_top_sva

bind scpa_top scpa_top_sva scpa_top_sva_inst (.*);

/* File: verif/test_scpa_top.sv */
// self-checking bench for strap capture and phase adjust
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module test_scpa_top;
  logic REF_CLK = 1'b0, SYS_RST = 1'b1, SPI_MISO_DATA = 1'b0, SPI_MISO_EN = 1'b0;
  logic PHASE_OP_SELECT, PHASE_ARM_BIT, PHASE_FIRE_BIT, PHASE_SM_CLEAR, ADJUST_DONE_CLEAR;
  logic [3:0] code = 4'h0;
  logic [2:0] OUT_INVERT, OUT_PHASE_ENABLE, OUT_INVERT_Q;
  logic [5:0] OUT_DRIVE_LEVEL, OUT_DRIVE_Q;
  logic [23:0] OUT_PHASE_AMOUNT;
  logic [1:0] REF_INPUT_SELECT, AUTO_CONFIG_STRAPS;
  logic TEST_PIN, IF0_CS_N_PIN, IF1_MISO_PIN, TEST_MODE, SPI_MODE, READY;
  logic XTAL_DRIVER_EN, XTAL_IN_SE_EN, CS_N_TO_PORT, MISO_OUT, MISO_OE;
  logic [4:0] STRAP_CAPTURE_STATUS;
  logic [6:0] I2C_SLAVE_ADDR;
  logic [47:0] OUT_PHASE;
  scpa_pkg::scpa_outcfg_type [2:0] OUT_CONFIG;
  scpa_pkg::scpa_status_type PHASE_STATUS;
  int err_total = 0;
  int total_checks = 0;
  int i;
  localparam logic [7:0] FMT2 = 8'h64; // second output format per config

  scpa_top scpa_top_inst (.*);
  scpa_strap_model scpa_strap_model_inst (.clk(REF_CLK), .rst(SYS_RST), .code(code),
    .test_pin(TEST_PIN), .pins({AUTO_CONFIG_STRAPS, IF1_MISO_PIN, IF0_CS_N_PIN}));

  // free running clock
  initial
  begin
    forever #25 REF_CLK = ~REF_CLK;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // reset with one strap code, then check the decode
  task automatic straps(input logic [1:0] c);
    code = {c, c};
    SPI_MISO_DATA = c[1];
    SPI_MISO_EN = 1'b1;
    SYS_RST = 1'b1;
    cyc(3);
    `CHK(READY, 1'b0)
    SYS_RST = 1'b0;
    cyc(2);
    `CHK(MISO_OE, 1'b0)
    for (i = 0; i < 20 && READY !== 1'b1; i++) cyc(1);
    if (READY !== 1'b1)
    begin
      err_total++;
      results();
    end
    `CHK(STRAP_CAPTURE_STATUS, {1'b0, c, c})
    `CHK(TEST_MODE, 1'b0)
    `CHK(I2C_SLAVE_ADDR, {5'h1B, c})
    `CHK(SPI_MODE, c == 2'h3)
    `CHK(OUT_CONFIG[0], {scpa_pkg::FMT_CML, scpa_pkg::FREQ_100})
    `CHK(OUT_CONFIG[1].fmt, FMT2[2*c+:2])
    `CHK(OUT_CONFIG[2].fmt, (c == 2'h3) ? scpa_pkg::FMT_CMOS : scpa_pkg::FMT_OFF)
    `CHK(OUT_CONFIG[1].freq_mhz, (c == 2'h0) ? 8'h00 : scpa_pkg::FREQ_100)
    `CHK(OUT_CONFIG[2].freq_mhz, (c == 2'h3) ? scpa_pkg::FREQ_25 : 8'h00)
    cyc(12);
    `CHK(STRAP_CAPTURE_STATUS, {1'b0, c, c})
    `CHK(CS_N_TO_PORT, ~c[0])
    `CHK(MISO_OE, 1'b1)
    `CHK(MISO_OUT, c[1])
  endtask

  task automatic pa(input logic a, input logic f, input int n);
    PHASE_ARM_BIT = a;
    PHASE_FIRE_BIT = f;
    cyc(n);
  endtask

  // clear, arm, fire, then compare accumulated phases
  task automatic run(input logic [2:0] en, input logic [23:0] amt, input logic [47:0] ex);
    OUT_PHASE_ENABLE = en;
    OUT_PHASE_AMOUNT = amt;
    PHASE_SM_CLEAR = 1'b1;
    ADJUST_DONE_CLEAR = 1'b1;
    pa(1'b0, 1'b0, 1);
    PHASE_SM_CLEAR = 1'b0;
    ADJUST_DONE_CLEAR = 1'b0;
    cyc(1);
    `CHK(PHASE_STATUS.done_sticky, 1'b0)
    pa(1'b1, 1'b0, 2);
    `CHK(PHASE_STATUS, 3'h4)
    pa(1'b1, 1'b1, 1);
    `CHK(PHASE_STATUS[2:1], 2'h1)
    for (i = 0; i < 10 && PHASE_STATUS.done_sticky !== 1'b1; i++) cyc(1);
    if (PHASE_STATUS.done_sticky !== 1'b1)
    begin
      err_total++;
      results();
    end
    `CHK(OUT_PHASE, ex)
  endtask

  initial
  begin
    {PHASE_OP_SELECT, PHASE_ARM_BIT, PHASE_FIRE_BIT, PHASE_SM_CLEAR, ADJUST_DONE_CLEAR} = 5'h00;
    {OUT_INVERT, OUT_PHASE_ENABLE, OUT_DRIVE_LEVEL, REF_INPUT_SELECT} = 14'h0000;
    OUT_PHASE_AMOUNT = 24'h000000;
    for (int c = 0; c < 4; c++) straps(2'(c));
    for (int s = 0; s < 4; s++)
    begin
      REF_INPUT_SELECT = 2'(s);
      OUT_INVERT = 3'(s + 1);
      OUT_DRIVE_LEVEL = {2'(s), 2'(3 - s), 2'(s ^ 1)};
      cyc(3);
      `CHK(XTAL_DRIVER_EN, s != 2)
      `CHK(XTAL_IN_SE_EN, s == 2)
      `CHK(OUT_INVERT_Q, OUT_INVERT)
      `CHK(OUT_DRIVE_Q, OUT_DRIVE_LEVEL)
    end
    OUT_PHASE_ENABLE = 3'h7;
    OUT_PHASE_AMOUNT = 24'h020202;
    pa(1'b1, 1'b0, 3);
    `CHK(PHASE_STATUS.armed, 1'b0)
    PHASE_OP_SELECT = 1'b1;
    pa(1'b1, 1'b1, 8);
    `CHK(PHASE_STATUS, 3'h0)
    pa(1'b0, 1'b0, 1);
    pa(1'b1, 1'b0, 2);
    PHASE_SM_CLEAR = 1'b1;
    cyc(1);
    PHASE_SM_CLEAR = 1'b0;
    `CHK(PHASE_STATUS.armed, 1'b0)
    pa(1'b1, 1'b1, 8);
    `CHK(OUT_PHASE, 48'h0)
    run(3'h3, 24'h02FC05, 48'h0000_FFFC_0005);
    run(3'h3, 24'h02FC05, 48'h0000_FFF8_000A);
    run(3'h7, 24'h7F0000, 48'h0030_FFF8_000A);
    results();
  end
endmodule // test_scpa_top
